/* verilog/cmb_defines.svh */
// address map, field positions and reset values of the core memory bus interface
`ifndef CMB_DEFINES_SVH
`define CMB_DEFINES_SVH

// bus widths
`define CMB_PROG_AW 21
`define CMB_DATA_AW 24
`define CMB_WORD_W 16
`define CMB_LONG_W 32

// byte accesses live in the lower half: this bit is cleared for them
`define CMB_DATA_MSB 23

// data space regions, word addresses, inclusive
`define CMB_DRAM_BASE 24'h000000
`define CMB_DRAM_LAST 24'h0007FF
`define CMB_DFLASH_BASE 24'h004000
`define CMB_DFLASH_LAST 24'h005FFF
`define CMB_IO_BASE 24'h00F000
`define CMB_IO_LAST 24'h00FFFF

// program space regions, word addresses, inclusive
`define CMB_PFLASH_BASE 21'h000000
`define CMB_PFLASH_LAST 21'h001FFF
`define CMB_PRAM_BASE 21'h008000
`define CMB_PRAM_LAST 21'h0087FF

// reset values
`define CMB_RST_DATA_ADDR 24'h000000
`define CMB_RST_PROG_ADDR 21'h000000
`define CMB_RST_WORD 16'h0000
`define CMB_RST_LONG 32'h00000000

`endif

/* verilog/cmb_pkg.sv */
// types shared by the core memory bus interface modules
package cmb_pkg;

    // memory that an access lands in
    typedef enum logic [1:0] {
        CMB_TGT_NONE  = 2'h0,
        CMB_TGT_RAM   = 2'h1,
        CMB_TGT_FLASH = 2'h2,
        CMB_TGT_IO    = 2'h3
    } cmb_target_t;

    // operand size on the primary data port
    typedef enum logic [1:0] {
        CMB_SIZE_BYTE = 2'h0,
        CMB_SIZE_WORD = 2'h1,
        CMB_SIZE_LONG = 2'h2
    } cmb_size_t;

    // arbitration state, gray along idle -> defer -> idle
    typedef enum logic [1:0] {
        CMB_ST_IDLE  = 2'h0,
        CMB_ST_DEFER = 2'h1
    } cmb_state_t;

endpackage

/* verilog/cmb_read_return.sv */
// read return lane: follows a read two cycles and registers the selected answer
module cmb_read_return #(
    parameter int W = 16
) (
    input wire logic mclk,
    input wire logic resetn,
    input wire logic issue,
    input wire cmb_pkg::cmb_target_t target,
    input wire logic [W-1:0] ramData,
    input wire logic [15:0] flashData,
    input wire logic [15:0] ioData,
    output logic [W-1:0] readData,
    output logic readValid
);
    import cmb_pkg::*;

    logic issue1;
    logic issue2;
    cmb_target_t tgt1;
    cmb_target_t tgt2;
    logic [W-1:0] next_readData;

    ////////////////////////////////////////////////////////////////////////////
    // pick the answer of the memory the read went to; unmapped reads return zero
    assign next_readData = (tgt2 == CMB_TGT_RAM) ? ramData :
                           (tgt2 == CMB_TGT_FLASH) ? W'(flashData) :
                           (tgt2 == CMB_TGT_IO) ? W'(ioData) : '0;

    ////////////////////////////////////////////////////////////////////////////
    // tag pipeline aligned with request outputs, then with memory data
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            issue1 <= 1'b0;
            issue2 <= 1'b0;
            tgt1 <= CMB_TGT_NONE;
            tgt2 <= CMB_TGT_NONE;
            readValid <= 1'b0;
            readData <= '0;
        end else begin
            issue1 <= issue;
            tgt1 <= target;
            issue2 <= issue1;
            tgt2 <= tgt1;
            readValid <= issue2;
            if (issue2) begin
                readData <= next_readData;
            end
        end
    end

endmodule

/* verilog/core_memory_bus_interface.sv */
// core memory bus interface: routes program and data accesses to ram, flash and i/o
//
// Behaviour
// - 21-bit program address, 16-bit program read bus
// - program writes take low 16 write bits
// - primary port: 24-bit address, 32-bit data
// - primary address also reaches memory-mapped i/o
// - secondary port: word reads only, 16-bit bus
// - byte access forces address msb to zero
// - primary ram port 32 bits, others 16
// - ram serves both data ports in one cycle without a stall, except in the deferred cycle after a flash or i/o conflict
// - flash reads/writes pass straight to arrays
`include "cmb_defines.svh"

module cmb_core_memory_bus_interface (
    input wire logic mclk,
    input wire logic resetn,
    // program port from the core
    input wire logic [20:0] progAddr,
    input wire logic progRead,
    input wire logic progWrite,
    output logic [15:0] progReadData,
    output logic progReadValid,
    // primary data port from the core
    input wire logic [23:0] primaryDataAddress,
    input wire logic priRead,
    input wire logic priWrite,
    input wire cmb_pkg::cmb_size_t priSize,
    input wire logic [31:0] priWriteData,
    output logic [31:0] priReadData,
    output logic priReadValid,
    // secondary data port from the core
    input wire logic [23:0] secondaryDataAddress,
    input wire logic secRead,
    output logic [15:0] secondaryReadBus,
    output logic secReadValid,
    output logic stall,
    // ram primary port, 32 bits
    output logic [23:0] ramAAddr,
    output logic ramARead,
    output logic ramAWrite,
    output cmb_pkg::cmb_size_t ramASize,
    output logic [31:0] ramAWriteData,
    input wire logic [31:0] ramAReadData,
    // ram secondary port, 16 bits, reads only
    output logic [23:0] ramBAddr,
    output logic ramBRead,
    input wire logic [15:0] ramBReadData,
    // ram program port, 16 bits
    output logic [20:0] ramPAddr,
    output logic ramPRead,
    output logic ramPWrite,
    output logic [15:0] ramPWriteData,
    input wire logic [15:0] ramPReadData,
    // flash interface unit, program port
    output logic [20:0] flashPAddr,
    output logic flashPRead,
    output logic flashPWrite,
    output logic [15:0] flashPWriteData,
    input wire logic [15:0] flashPReadData,
    // flash interface unit, data port
    output logic [23:0] flashDAddr,
    output logic flashDRead,
    output logic flashDWrite,
    output logic [15:0] flashDWriteData,
    input wire logic [15:0] flashDReadData,
    // memory-mapped i/o toward the peripheral bridge
    output logic [23:0] ioAddr,
    output logic ioRead,
    output logic ioWrite,
    output logic [15:0] ioWriteData,
    input wire logic [15:0] ioReadData
);
    import cmb_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // address decoders, one map for each space
    function automatic cmb_target_t decodeData(input logic [23:0] addr);
        if (addr >= `CMB_DRAM_BASE && addr <= `CMB_DRAM_LAST) begin
            return CMB_TGT_RAM;
        end else if (addr >= `CMB_DFLASH_BASE && addr <= `CMB_DFLASH_LAST) begin
            return CMB_TGT_FLASH;
        end else if (addr >= `CMB_IO_BASE && addr <= `CMB_IO_LAST) begin
            return CMB_TGT_IO;
        end else begin
            return CMB_TGT_NONE;
        end
    endfunction

    function automatic cmb_target_t decodeProg(input logic [20:0] addr);
        if (addr >= `CMB_PFLASH_BASE && addr <= `CMB_PFLASH_LAST) begin
            return CMB_TGT_FLASH;
        end else if (addr >= `CMB_PRAM_BASE && addr <= `CMB_PRAM_LAST) begin
            return CMB_TGT_RAM;
        end else begin
            return CMB_TGT_NONE;
        end
    endfunction

    cmb_state_t state;
    cmb_state_t next_state;
    logic [23:0] heldSecAddr;
    cmb_target_t heldSecTgt;

    ////////////////////////////////////////////////////////////////////////////
    // request qualification and target decode
    wire priByte = (priSize == CMB_SIZE_BYTE);
    wire [23:0] priAddrEff = priByte ? {1'b0, primaryDataAddress[`CMB_DATA_MSB-1:0]}
                                     : primaryDataAddress;
    wire cmb_target_t priTgt = decodeData(priAddrEff);
    wire cmb_target_t secTgtIn = decodeData(secondaryDataAddress);
    wire cmb_target_t progTgt = decodeProg(progAddr);
    wire accept = (state == CMB_ST_IDLE); // requests seen while stalled are dropped
    wire progGo = accept && (progRead || progWrite);
    wire priGo = accept && (priRead || priWrite);
    wire secGo = accept && secRead;

    ////////////////////////////////////////////////////////////////////////////
    // conflict: ram is dual ported, flash and i/o data ports are not
    wire shared = (priTgt == CMB_TGT_FLASH) || (priTgt == CMB_TGT_IO);
    wire conflict = priGo && secGo && (priTgt == secTgtIn) && shared;
    wire deferred = (state == CMB_ST_DEFER);
    wire secIssue = (secGo && !conflict) || deferred;
    wire [23:0] secAddrIssue = deferred ? heldSecAddr : secondaryDataAddress;
    wire cmb_target_t secTgtIssue = deferred ? heldSecTgt : secTgtIn;

    ////////////////////////////////////////////////////////////////////////////
    // per-target request strobes
    wire priRam = priGo && (priTgt == CMB_TGT_RAM);
    wire priFlash = priGo && (priTgt == CMB_TGT_FLASH);
    wire priIo = priGo && (priTgt == CMB_TGT_IO);
    wire secRam = secIssue && (secTgtIssue == CMB_TGT_RAM);
    wire secFlash = secIssue && (secTgtIssue == CMB_TGT_FLASH);
    wire secIo = secIssue && (secTgtIssue == CMB_TGT_IO);
    wire progRam = progGo && (progTgt == CMB_TGT_RAM);
    wire progFlash = progGo && (progTgt == CMB_TGT_FLASH);
    wire [15:0] progWord = priWriteData[15:0];

    ////////////////////////////////////////////////////////////////////////////
    // shared 16-bit data ports: primary owns them unless the secondary is alone
    wire [23:0] flashDAddrSel = priFlash ? priAddrEff : secAddrIssue;
    wire [23:0] ioAddrSel = priIo ? priAddrEff : secAddrIssue;

    ////////////////////////////////////////////////////////////////////////////
    // arbitration state and the held secondary request
    assign next_state = conflict ? CMB_ST_DEFER : CMB_ST_IDLE;

    always_ff @(posedge mclk) begin
        if (!resetn) begin
            state <= CMB_ST_IDLE;
            stall <= 1'b0;
            heldSecAddr <= `CMB_RST_DATA_ADDR;
            heldSecTgt <= CMB_TGT_NONE;
        end else begin
            state <= next_state;
            stall <= conflict;
            if (conflict) begin
                heldSecAddr <= secondaryDataAddress;
                heldSecTgt <= secTgtIn;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // ram ports: 32-bit primary, 16-bit secondary and program
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            ramAAddr <= `CMB_RST_DATA_ADDR;
            ramARead <= 1'b0;
            ramAWrite <= 1'b0;
            ramASize <= CMB_SIZE_WORD;
            ramAWriteData <= `CMB_RST_LONG;
            ramBAddr <= `CMB_RST_DATA_ADDR;
            ramBRead <= 1'b0;
            ramPAddr <= `CMB_RST_PROG_ADDR;
            ramPRead <= 1'b0;
            ramPWrite <= 1'b0;
            ramPWriteData <= `CMB_RST_WORD;
        end else begin
            ramAAddr <= priAddrEff;
            ramARead <= priRam && priRead;
            ramAWrite <= priRam && priWrite;
            ramASize <= priSize;
            ramAWriteData <= priWriteData;
            ramBAddr <= secAddrIssue;
            ramBRead <= secRam;
            ramPAddr <= progAddr;
            ramPRead <= progRam && progRead;
            ramPWrite <= progRam && progWrite;
            ramPWriteData <= progWord;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // flash arrays: reads and writes only, control goes over the peripheral bus
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            flashPAddr <= `CMB_RST_PROG_ADDR;
            flashPRead <= 1'b0;
            flashPWrite <= 1'b0;
            flashPWriteData <= `CMB_RST_WORD;
            flashDAddr <= `CMB_RST_DATA_ADDR;
            flashDRead <= 1'b0;
            flashDWrite <= 1'b0;
            flashDWriteData <= `CMB_RST_WORD;
        end else begin
            flashPAddr <= progAddr;
            flashPRead <= progFlash && progRead;
            flashPWrite <= progFlash && progWrite;
            flashPWriteData <= progWord;
            flashDAddr <= flashDAddrSel;
            flashDRead <= (priFlash && priRead) || secFlash;
            flashDWrite <= priFlash && priWrite;
            flashDWriteData <= priWriteData[15:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // memory-mapped i/o reached through the primary or secondary address
    always_ff @(posedge mclk) begin
        if (!resetn) begin
            ioAddr <= `CMB_RST_DATA_ADDR;
            ioRead <= 1'b0;
            ioWrite <= 1'b0;
            ioWriteData <= `CMB_RST_WORD;
        end else begin
            ioAddr <= ioAddrSel;
            ioRead <= (priIo && priRead) || secIo;
            ioWrite <= priIo && priWrite;
            ioWriteData <= priWriteData[15:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // read return lanes, one per core read bus
    cmb_read_return #(.W(16)) progReturn (
        .mclk(mclk),
        .resetn(resetn),
        .issue(progGo && progRead),
        .target(progTgt),
        .ramData(ramPReadData),
        .flashData(flashPReadData),
        .ioData(16'h0000),
        .readData(progReadData),
        .readValid(progReadValid)
    );

    cmb_read_return #(.W(32)) priReturn (
        .mclk(mclk),
        .resetn(resetn),
        .issue(priGo && priRead),
        .target(priTgt),
        .ramData(ramAReadData),
        .flashData(flashDReadData),
        .ioData(ioReadData),
        .readData(priReadData),
        .readValid(priReadValid)
    );

    cmb_read_return #(.W(16)) secReturn (
        .mclk(mclk),
        .resetn(resetn),
        .issue(secIssue),
        .target(secTgtIssue),
        .ramData(ramBReadData),
        .flashData(flashDReadData),
        .ioData(ioReadData),
        .readData(secondaryReadBus),
        .readValid(secReadValid)
    );

endmodule

/* verification/cmb_core_memory_bus_interface_assertions.sv */
// port checker of the core memory bus interface
module cmb_core_memory_bus_interface_assertions
    import cmb_pkg::*;
(
    input wire logic mclk,
    input wire logic resetn,
    input wire logic [20:0] progAddr,
    input wire logic progRead,
    input wire logic [23:0] primaryDataAddress,
    input wire logic priRead,
    input wire logic [23:0] secondaryDataAddress,
    input wire logic secRead,
    input wire logic stall,
    input wire logic [23:0] ramAAddr,
    input wire logic ramARead,
    input wire cmb_pkg::cmb_size_t ramASize,
    input wire logic [31:0] ramAReadData,
    input wire logic [31:0] priReadData,
    input wire logic priReadValid,
    input wire logic ramBRead,
    input wire logic [15:0] ramBReadData,
    input wire logic [15:0] secondaryReadBus,
    input wire logic secReadValid,
    input wire logic [23:0] ioAddr,
    input wire logic ioRead,
    input wire logic [20:0] flashPAddr,
    input wire logic flashPRead
);
    timeunit 1ns;
    timeprecision 100ps;
    // region decodes of the request addresses
    wire priRam = primaryDataAddress <= 24'h0007FF;
    wire secRam = secondaryDataAddress <= 24'h0007FF;
    wire priIo = primaryDataAddress >= 24'h00F000 && primaryDataAddress <= 24'h00FFFF;
    wire secIo = secondaryDataAddress >= 24'h00F000 && secondaryDataAddress <= 24'h00FFFF;
    wire priTaken = priRead && !stall;
    default clocking @(posedge mclk); endclocking
    default disable iff (!resetn);
    ////////////////////////////////////////////////////////////////////////////////
    sequence s_both_io;
        priTaken && secRead && priIo && secIo;
    endsequence
    property p_ram_read;
        priTaken && priRam |=> ramARead && ramAAddr == $past(primaryDataAddress);
    endproperty
    a_ram_read: assert property (p_ram_read) else $error("ram read missing");
    property p_byte_msb;
        ramARead && ramASize == CMB_SIZE_BYTE |-> !ramAAddr[23];
    endproperty
    a_byte_msb: assert property (p_byte_msb) else $error("byte msb set");
    property p_long_ret;
        ramARead && ramASize == CMB_SIZE_LONG |->
            ##2 priReadValid && priReadData == $past(ramAReadData);
    endproperty
    a_long_ret: assert property (p_long_ret) else $error("long data lost");
    property p_sec_ret;
        ramBRead |-> ##2 secReadValid && secondaryReadBus == $past(ramBReadData);
    endproperty
    a_sec_ret: assert property (p_sec_ret) else $error("secondary data lost");
    property p_io;
        priTaken && priIo |=> ioRead && ioAddr == $past(primaryDataAddress);
    endproperty
    a_io: assert property (p_io) else $error("io access missing");
    property p_dual;
        priTaken && secRead && priRam && secRam |=> ramARead && ramBRead && !stall;
    endproperty
    a_dual: assert property (p_dual) else $error("dual ram read failed");
    property p_conflict;
        s_both_io |=> stall ##1 (!stall && ioRead && ioAddr == $past(secondaryDataAddress, 2));
    endproperty
    a_conflict: assert property (p_conflict) else $error("conflict not deferred");
    property p_flash;
        progRead && !stall && progAddr <= 21'h001FFF |=>
            flashPRead && flashPAddr == $past(progAddr);
    endproperty
    a_flash: assert property (p_flash) else $error("flash fetch missing");
endmodule

/* verification/cmb_mem_model.sv */
// memories behind the interface: one-cycle registered reads
module cmb_mem_model (
    input wire logic mclk,
    input wire logic [23:0] ramAAddr,
    input wire logic ramARead,
    output logic [31:0] ramAReadData,
    input wire logic [23:0] ramBAddr,
    input wire logic ramBRead,
    output logic [15:0] ramBReadData,
    input wire logic [20:0] ramPAddr,
    input wire logic ramPRead,
    output logic [15:0] ramPReadData,
    input wire logic [20:0] flashPAddr,
    input wire logic flashPRead,
    output logic [15:0] flashPReadData,
    input wire logic [23:0] flashDAddr,
    input wire logic flashDRead,
    output logic [15:0] flashDReadData,
    input wire logic [23:0] ioAddr,
    input wire logic ioRead,
    output logic [15:0] ioReadData
);
    timeunit 1ns;
    timeprecision 100ps;
    initial begin
        {ramAReadData, ramBReadData, ramPReadData} = 64'h0;
        {flashPReadData, flashDReadData, ioReadData} = 48'h0;
    end
    // answer the cycle after a strobe, otherwise scramble so nothing stale passes
    always @(posedge mclk) begin
        ramAReadData <= ramARead ? {~ramAAddr[15:0], ramAAddr[15:0]} : ~ramAReadData;
        ramBReadData <= ramBRead ? ramBAddr[15:0] ^ 16'h5A5A : ~ramBReadData;
        ramPReadData <= ramPRead ? ramPAddr[15:0] ^ 16'h1234 : ~ramPReadData;
        flashPReadData <= flashPRead ? flashPAddr[15:0] ^ 16'hC3C3 : ~flashPReadData;
        flashDReadData <= flashDRead ? flashDAddr[15:0] ^ 16'h3C3C : ~flashDReadData;
        ioReadData <= ioRead ? ioAddr[15:0] ^ 16'h0F0F : ~ioReadData;
    end
endmodule

/* verification/cmb_core_memory_bus_interface_tb_top.sv */
// self-checking bench of the core memory bus interface
module cmb_core_memory_bus_interface_tb_top import cmb_pkg::*;;
    timeunit 1ns;
    timeprecision 100ps;
    logic mclk, resetn, progRead, progWrite, progReadValid, priRead, priWrite, priReadValid;
    logic secRead, secReadValid, stall, ramARead, ramAWrite, ramBRead, ramPRead, ramPWrite;
    logic flashPRead, flashPWrite, flashDRead, flashDWrite, ioRead, ioWrite;
    logic [20:0] progAddr, ramPAddr, flashPAddr;
    logic [15:0] progReadData, secondaryReadBus, ramBReadData, ramPWriteData, ramPReadData;
    logic [15:0] flashPWriteData, flashPReadData, flashDWriteData, flashDReadData;
    logic [15:0] ioWriteData, ioReadData;
    logic [23:0] primaryDataAddress, secondaryDataAddress, ramAAddr, ramBAddr, flashDAddr, ioAddr;
    logic [31:0] priWriteData, priReadData, ramAWriteData, ramAReadData;
    cmb_size_t priSize, ramASize;
    int failures, nCompared, cycles;
    cmb_core_memory_bus_interface u_dut (.mclk, .resetn, .progAddr, .progRead, .progWrite,
        .progReadData, .progReadValid, .primaryDataAddress, .priRead, .priWrite, .priSize,
        .priWriteData, .priReadData, .priReadValid, .secondaryDataAddress, .secRead,
        .secondaryReadBus, .secReadValid, .stall, .ramAAddr, .ramARead, .ramAWrite, .ramASize,
        .ramAWriteData, .ramAReadData, .ramBAddr, .ramBRead, .ramBReadData, .ramPAddr,
        .ramPRead, .ramPWrite, .ramPWriteData, .ramPReadData, .flashPAddr, .flashPRead,
        .flashPWrite, .flashPWriteData, .flashPReadData, .flashDAddr, .flashDRead, .flashDWrite,
        .flashDWriteData, .flashDReadData, .ioAddr, .ioRead, .ioWrite, .ioWriteData, .ioReadData);
    cmb_mem_model u_mem (.mclk, .ramAAddr, .ramARead, .ramAReadData, .ramBAddr, .ramBRead,
        .ramBReadData, .ramPAddr, .ramPRead, .ramPReadData, .flashPAddr, .flashPRead,
        .flashPReadData, .flashDAddr, .flashDRead, .flashDReadData, .ioAddr, .ioRead, .ioReadData);
    ////////////////////////////////////////////////////////////////////////////////
    always #12.5 mclk = ~mclk;
    // hang guard
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 3000) begin
            failures++;
            end_sim();
        end
    end
    task automatic tick();
        @(posedge mclk);
        #1;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        nCompared++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic end_sim();
        if (failures == 0 && nCompared > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    // flash fetch at the top of the program flash region, then a program ram write
    task automatic t_prog();
        progAddr = 21'h001FFF;
        progRead = 1'b1;
        tick();
        progRead = 1'b0;
        chk({flashPRead, 10'h0, flashPAddr}, {1'b1, 10'h0, 21'h001FFF});
        tick();
        tick();
        chk({progReadValid, progReadData}, {1'b1, 16'h1FFF ^ 16'hC3C3});
        progAddr = 21'h008010;
        priWriteData = 32'hDEAD5A5A;
        progWrite = 1'b1;
        tick();
        progWrite = 1'b0;
        chk({ramPWrite, ramPWriteData}, {1'b1, 16'h5A5A});
    endtask
    // primary long read and write on the wide ram port
    task automatic t_long();
        primaryDataAddress = 24'h000123;
        priSize = CMB_SIZE_LONG;
        priRead = 1'b1;
        tick();
        priRead = 1'b0;
        chk({ramARead, ramAAddr}, {1'b1, 24'h000123});
        tick();
        tick();
        chk(priReadData, {~16'h0123, 16'h0123});
        priWriteData = 32'h89ABCDEF;
        priWrite = 1'b1;
        tick();
        priWrite = 1'b0;
        chk({ramAWrite, ramAWriteData[30:0]}, {1'b1, 31'h09ABCDEF});
    endtask
    // byte access with the top address bit set lands in the lower half
    task automatic t_byte();
        primaryDataAddress = 24'h800045;
        priSize = CMB_SIZE_BYTE;
        priRead = 1'b1;
        tick();
        priRead = 1'b0;
        chk({ramARead, ramAAddr}, {1'b1, 24'h000045});
        tick();
    endtask
    // primary write to memory-mapped io takes the low half of the data
    task automatic t_io();
        primaryDataAddress = 24'h00F010;
        priSize = CMB_SIZE_WORD;
        priWriteData = 32'h1234ABCD;
        priWrite = 1'b1;
        tick();
        priWrite = 1'b0;
        chk({ioWrite, ioWriteData}, {1'b1, 16'hABCD});
        chk(ioAddr, 24'h00F010);
    endtask
    // two ram operands in one cycle, no stall
    task automatic t_dual();
        primaryDataAddress = 24'h000010;
        secondaryDataAddress = 24'h000020;
        {priRead, secRead} = 2'b11;
        tick();
        {priRead, secRead} = 2'b00;
        chk({ramARead, ramBRead, stall, ramBAddr}, {3'b110, 24'h000020});
        tick();
        tick();
        chk({priReadValid, secReadValid, secondaryReadBus}, {2'b11, 16'h0020 ^ 16'h5A5A});
    endtask
    // both operands to io: secondary deferred, request during stall dropped
    task automatic t_conflict();
        primaryDataAddress = 24'h00F001;
        secondaryDataAddress = 24'h00F002;
        {priRead, secRead} = 2'b11;
        tick();
        secRead = 1'b0;
        chk({ioRead, stall, ioAddr}, {2'b11, 24'h00F001});
        primaryDataAddress = 24'h000010;
        tick();
        priRead = 1'b0;
        chk({ioRead, stall, ramARead, ioAddr}, {3'b100, 24'h00F002});
        tick();
        chk({priReadValid, priReadData[15:0]}, {1'b1, 16'hF001 ^ 16'h0F0F});
        tick();
        chk({secReadValid, secondaryReadBus}, {1'b1, 16'hF002 ^ 16'h0F0F});
    endtask
    // flash writes on both ports, then both operands to data flash beside a program ram fetch
    task automatic t_flash();
        primaryDataAddress = 24'h004100;
        progAddr = 21'h000200;
        priWriteData = 32'hCAFE1357;
        {priWrite, progWrite} = 2'b11;
        tick();
        {priWrite, progWrite} = 2'b00;
        chk({flashDWrite, flashPWrite, flashDWriteData}, {2'b11, 16'h1357});
        chk({flashPWriteData, flashPAddr[15:0]}, {16'h1357, 16'h0200});
        chk(flashDAddr, 24'h004100);
        primaryDataAddress = 24'h004001;
        secondaryDataAddress = 24'h004002;
        progAddr = 21'h008003;
        {priRead, secRead, progRead} = 3'b111;
        tick();
        {priRead, secRead, progRead} = 3'b000;
        chk({flashDRead, stall, ramPRead, flashDAddr}, {3'b111, 24'h004001});
        tick();
        chk({flashDRead, stall, flashDAddr}, {2'b10, 24'h004002});
        tick();
        chk({priReadValid, priReadData[15:0]}, {1'b1, 16'h4001 ^ 16'h3C3C});
        chk({progReadValid, progReadData}, {1'b1, 16'h8003 ^ 16'h1234});
        tick();
        chk({secReadValid, secondaryReadBus}, {1'b1, 16'h4002 ^ 16'h3C3C});
    endtask
    initial begin
        {mclk, resetn, progRead, progWrite, priRead, priWrite, secRead} = 7'h00;
        {progAddr, primaryDataAddress, secondaryDataAddress} = 69'h0;
        priWriteData = 32'h0;
        priSize = CMB_SIZE_WORD;
        repeat (16) @(posedge mclk);
        #1 resetn = 1'b1;
        tick();
        t_prog();
        t_long();
        t_byte();
        t_io();
        t_dual();
        t_conflict();
        t_flash();
        end_sim();
    end
endmodule

bind cmb_core_memory_bus_interface cmb_core_memory_bus_interface_assertions u_chk (.mclk,
    .resetn, .progAddr, .progRead, .primaryDataAddress, .priRead, .secondaryDataAddress,
    .secRead, .stall, .ramAAddr, .ramARead, .ramASize, .ramAReadData, .priReadData,
    .priReadValid, .ramBRead, .ramBReadData, .secondaryReadBus, .secReadValid, .ioAddr,
    .ioRead, .flashPAddr, .flashPRead);
